// ===== include/hodo_pkg.sv
// How it works
// [R1] Sample all 64 scintillator channel inputs to find the track position.
// [R2] Channels split as X and Y, sixteen each per plane, two planes.
// [R3] On a hit, raise the acquisition trigger after a programmable delay, 10 ns steps; code rounds the delay up to whole 40 ns clocks.
// [R4] Delay setting spans 100 ns to 300 ns.
// [R5] Latch all 64 channel states on each hit as the track record.
// [R6] Latched 64-bit record is offered to the host after a hit.
// [R7] Notify the host whenever a hit was detected.
// [R8] After each stored track the host re-arms the device before the next hit.
// [R9] Host reads and commands may travel over a USB link.
// [R10] All 64 inputs are sampled before the trigger for that hit.
// [R11] Record is fully latched before the host is notified.
// [R12] Trigger only on a qualified hit, never spontaneously.
// [R13] Nominal delay 200 ns, adjustable 100 to 300 ns in 10 ns steps; code rounds each delay up to whole 40 ns clocks.
// [R14] Hit needs one X and one Y active in each plane; delay counted in 10 ns ticks.
// [R15] While awaiting readout and re-arm, no overwrite and no new trigger.
package hodo_pkg;
    localparam int CHANNELS = 64;
    localparam int PLANE_AXIS = 16;
    localparam int CLK_PERIOD_NS = 40;
    localparam int DELAY_STEP_NS = 10;
    localparam int DELAY_MIN_NS = 100;
    localparam int DELAY_MAX_NS = 300;
    localparam int DELAY_NOM_NS = 200;
    // Delay code counts 10 ns steps
    localparam logic [4:0] DELAY_MIN_CODE = 5'(DELAY_MIN_NS / DELAY_STEP_NS);
    localparam logic [4:0] DELAY_MAX_CODE = 5'(DELAY_MAX_NS / DELAY_STEP_NS);
    localparam logic [4:0] DELAY_NOM_CODE = 5'(DELAY_NOM_NS / DELAY_STEP_NS);
    // Steps gained per clock: 40 ns clock advances 4 steps
    localparam logic [4:0] STEPS_PER_CLK = 5'(CLK_PERIOD_NS / DELAY_STEP_NS);
    localparam int TRIG_PULSE_CYCLES = 1;

    // One plane: X and Y channel groups
    typedef struct packed {
        logic [15:0] y;
        logic [15:0] x;
    } plane_t;

    // Whole track record, plane 2 in the upper half
    typedef struct packed {
        plane_t p2;
        plane_t p1;
    } track_t;

    typedef enum logic [1:0] {ARMED, DELAYING, HELD} hodo_state_t;
endpackage : hodo_pkg

// ===== verilog/hodo_capture.sv
module hodo_capture (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Scintillator channels, asynchronous pins
    input wire hodo_pkg::track_t chan_in,
    // Host control
    input wire logic [4:0] delay_code,
    input wire logic rearm,
    // Acquisition board
    output logic acq_trigger,
    // Host status and data
    output logic hit_flag,
    output hodo_pkg::track_t track_out
);
    hodo_pkg::track_t sync1_ff, sync2_ff, track_ff, nxt_track;
    hodo_pkg::hodo_state_t state_ff, nxt_state;
    logic [9:0] acc_ff, nxt_acc;
    logic [9:0] target_ff, nxt_target;
    logic trig_ff, nxt_trig, flag_ff, nxt_flag;
    logic hit_now;
    logic [4:0] code_clip;
    logic rearm_s1_ff, rearm_s2_ff;
    logic [4:0] code_s1_ff, code_s2_ff;

    // Two-stage synchroniser for channels and host pins
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            rearm_s1_ff <= 1'b0;
            rearm_s2_ff <= 1'b0;
            code_s1_ff <= hodo_pkg::DELAY_NOM_CODE;
            code_s2_ff <= hodo_pkg::DELAY_NOM_CODE;
        end else begin
            sync1_ff <= chan_in;
            sync2_ff <= sync1_ff; // [R1] [R10]
            rearm_s1_ff <= rearm;
            rearm_s2_ff <= rearm_s1_ff; // Same depth as channels
            code_s1_ff <= delay_code;
            code_s2_ff <= code_s1_ff;
        end
    end

    // Coincidence in both axes of both planes
    assign hit_now = (|sync2_ff.p1.x) & (|sync2_ff.p1.y) &
                     (|sync2_ff.p2.x) & (|sync2_ff.p2.y); // [R2] [R14] [R12]

    // Clamp delay code into legal span
    always_comb begin
        if (code_s2_ff < hodo_pkg::DELAY_MIN_CODE) begin
            code_clip = hodo_pkg::DELAY_MIN_CODE; // [R4]
        end else if (code_s2_ff > hodo_pkg::DELAY_MAX_CODE) begin
            code_clip = hodo_pkg::DELAY_MAX_CODE; // [R4] [R13]
        end else begin
            code_clip = code_s2_ff;
        end
    end

    // Next-state logic for capture sequence
    always_comb begin
        nxt_state = state_ff;
        nxt_track = track_ff;
        nxt_acc = acc_ff;
        nxt_target = target_ff;
        nxt_trig = 1'b0;
        nxt_flag = flag_ff;
        unique case (state_ff)
            hodo_pkg::ARMED: begin
                if (hit_now) begin
                    nxt_track = sync2_ff; // [R5]
                    nxt_acc = {5'h00, hodo_pkg::STEPS_PER_CLK};
                    nxt_target = {5'h00, code_clip}; // [R3] [R13]
                    nxt_state = hodo_pkg::DELAYING;
                end
            end
            hodo_pkg::DELAYING: begin
                if (acc_ff >= target_ff) begin
                    nxt_trig = 1'b1; // [R3] [R10]
                    nxt_flag = 1'b1; // [R7] [R11] [R6]
                    nxt_state = hodo_pkg::HELD;
                end else begin
                    nxt_acc = acc_ff + {5'h00, hodo_pkg::STEPS_PER_CLK};
                end
            end
            hodo_pkg::HELD: begin
                if (rearm_s2_ff) begin // [R8] [R9]
                    nxt_flag = 1'b0;
                    nxt_state = hodo_pkg::ARMED;
                end // [R15]
            end
        endcase
    end

    // Registers of capture sequence
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= hodo_pkg::ARMED;
            track_ff <= '0;
            acc_ff <= 10'h000;
            target_ff <= {5'h00, hodo_pkg::DELAY_NOM_CODE};
            trig_ff <= 1'b0;
            flag_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            track_ff <= nxt_track;
            acc_ff <= nxt_acc;
            target_ff <= nxt_target;
            trig_ff <= nxt_trig;
            flag_ff <= nxt_flag;
        end
    end

    assign acq_trigger = trig_ff;
    assign hit_flag = flag_ff;
    assign track_out = track_ff;
endmodule : hodo_capture

// ===== sim/host_model.sv
module host_model (
    // Clock, status and command
    input wire logic clk,
    input wire logic hit_flag,
    output logic rearm
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    initial rearm = 1'b0;
    // Re-arm once the record has sat for ten cycles
    always @(negedge clk) begin
        n <= hit_flag ? n + 1 : 0;
        rearm <= hit_flag && n > 9;
    end
endmodule : host_model

// ===== sim/hodo_monitor.sv
module hodo_monitor (
    // Clock, reset and watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic rearm,
    input wire logic acq_trigger,
    input wire logic hit_flag,
    input wire hodo_pkg::track_t track_out
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Record holds a coincidence
    wire c_rec = |track_out.p1.x && |track_out.p1.y && |track_out.p2.x && |track_out.p2.y;
    // Trigger, flag and record
    a_trig_gap: assert property (acq_trigger |=> !acq_trigger [*2]) else $error("trig");
    a_trig_flag: assert property (acq_trigger |-> hit_flag && !$past(hit_flag))
        else $error("flag");
    a_flag_cause: assert property ($rose(hit_flag) |-> acq_trigger) else $error("cause");
    a_trig_qual: assert property (acq_trigger |-> c_rec) else $error("qual");
    a_flag_hold: assert property (hit_flag && !rearm && !$past(rearm) && !$past(rearm, 2)
        |=> hit_flag) else $error("hold");
    a_rearm_drop: assert property (hit_flag && rearm |-> ##3 !hit_flag) else $error("rearm");
    a_rec_keep: assert property (hit_flag |=> $stable(track_out)) else $error("keep");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !hit_flag)
        else $error("reset");
    // Main scenarios
    cover property (acq_trigger);
    cover property (hit_flag && rearm);
    cover property ($fell(hit_flag));
endmodule : hodo_monitor
bind hodo_capture hodo_monitor u_mon (.*);

// ===== sim/tb_hodoscope_trigger_track_capture.sv
module tb_hodoscope_trigger_track_capture;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [63:0] pat; logic [4:0] code; int extra;} row_t;
    // Pattern, delay code, trigger cycles beyond row 1 (-1: no trigger)
    row_t rows[6] = '{'{64'h100010001, 5'h0A, -1}, '{64'h1000100010001, 5'h0A, 0},
        '{64'h8000800080008000, 5'h1E, 5}, '{64'h4000200010008, 5'h00, 0},
        '{64'hF000F000F000F, 5'h14, 2}, '{64'h10001000100010, 5'h1F, 5}};
    logic clk = 1'b0, rst = 1'b1, rearm, acq_trigger, hit_flag;
    logic [4:0] delay_code = 5'h14;
    hodo_pkg::track_t chan_in = '0, track_out;
    int num_errors = 0, num_checks = 0, cyc = 0, lat, base;
    hodo_capture dut (.*);
    host_model host (.*);
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial forever #20 clk = ~clk;
    // Cycle ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc > 1000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // Rows, then a hit cut off by reset
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            chan_in = rows[i].pat;
            delay_code = rows[i].code;
            lat = 0;
            while (acq_trigger !== 1'b1 && lat < 20) begin
                @(negedge clk);
                lat++;
            end
            if (i == 1) base = lat;
            if (rows[i].extra < 0) check(lat, 20);
            else check(lat - base, rows[i].extra);
            chan_in = rows[i].pat << 1;
            repeat (6) @(negedge clk);
            check(track_out, rows[i].extra < 0 ? 64'h0 : rows[i].pat);
            check(hit_flag, rows[i].extra >= 0);
            chan_in = '0;
            repeat (10) @(negedge clk);
            check(hit_flag, 1'b0);
            $display("row %0d done", i);
        end
        chan_in = rows[1].pat;
        repeat (4) @(negedge clk);
        rst = 1'b1;
        chan_in = '0;
        @(negedge clk);
        rst = 1'b0;
        repeat (12) @(negedge clk);
        check({acq_trigger, hit_flag, track_out[61:0]}, 64'h0);
        check(track_out, 64'h0);
        $display("reset test done");
        tally_and_finish();
    end
endmodule : tb_hodoscope_trigger_track_capture
